// file: src/irs_pkg.sv
package irs_pkg;

  // Bus address of this slave
  localparam logic [6:0] IRS_DEV_ADDR = 7'h17;
  localparam logic [3:0] IRS_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] IRS_ACK_BITS = 4'h1;
  localparam logic [7:0] IRS_PTR_RESET = 8'h00;
  localparam logic [7:0] IRS_BYTE_RESET = 8'h00;
  localparam logic [3:0] IRS_CNT_RESET = 4'h0;

  typedef enum logic [2:0] {
    IRS_IDLE     = 3'b000,
    IRS_ADDR     = 3'b001,
    IRS_REG      = 3'b010,
    IRS_DATA_WR  = 3'b011,
    IRS_DEV_ACK  = 3'b100,
    IRS_DATA_RD  = 3'b101,
    IRS_HOST_ACK = 3'b110,
    IRS_IGNORE   = 3'b111
  } irs_state_t;

  // Register write strobe with its address and data
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } irs_reg_req_t;

  // State of the link-clock sampler
  typedef struct packed {
    logic bit_val;
    logic tgl;
  } irs_link_t;

  // State of the core-clock protocol engine
  typedef struct packed {
    irs_state_t st;
    irs_state_t from;
    logic rw;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic oe;
    irs_reg_req_t req;
    logic rd_pulse;
    logic busy;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic tg_s1;
    logic tg_s2;
    logic tg_s3;
  } irs_core_t;

endpackage

// file: src/irs_link_sampler.sv
`timescale 1ns/1ps
module irs_link_sampler
(
  input wire logic scl,
  input wire logic rst,
  input wire logic sda_i,
  output irs_pkg::irs_link_t link
);

  irs_pkg::irs_link_t state_r;
  irs_pkg::irs_link_t state_nxt;

  // Each SCL rising edge carries one data bit; the toggle marks its arrival
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.bit_val = sda_i;
    state_nxt.tgl = ~state_r.tgl;
  end

  // SCL only clocks this flop; it is never driven by the device
  always_ff @(posedge scl or posedge rst)
  begin
    if (rst)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign link = state_r;

endmodule

// file: src/irs_slave.sv
`timescale 1ns/1ps
// Functional notes
// - SCL is an input only; the device never drives or stretches it.
// - SDA is sampled, and driven only low through open drain.
// - Transfer is START, address plus direction, register byte, data bytes, STOP.
// - Idle bus has both lines high; no SDA drive outside a transfer.
// - SDA fall with SCL high is START; SDA rise with SCL high is STOP.
// - One bit per SCL pulse; SDA changes during SCL high are control.
// - Ninth pulse is acknowledge; receiver holds SDA low through its high phase.
// - Device acknowledges every byte the master writes to it.
// - Device answers only bus address 0010 111 after a START.
// - Bit after the address: 0 is write, 1 is read.
// - Any START resets the interface and decodes a new address byte.
// - First written byte after the address loads the register pointer.
// - STOP after the register byte only keeps the new pointer.
// - Data bytes go to the pointed register, pointer increments after each.
// - Read returns the pointed register first, then increments per byte.
// - A not-acknowledge from the master releases SDA until the next START.
module irs_slave
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output irs_pkg::irs_reg_req_t reg_req,
  output logic [7:0] reg_rd_addr,
  input wire logic [7:0] reg_rdata,
  output logic reg_rd_strobe,
  output logic bus_busy,
  output logic addressed
);

  irs_pkg::irs_link_t link;
  irs_pkg::irs_core_t q_r;
  irs_pkg::irs_core_t q_nxt;
  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic fall_ev;

  // Bits are sampled on SCL itself so data never depends on core oversampling
  irs_link_sampler u_sampler
  (
    .scl(scl),
    .rst(rst),
    .sda_i(sda_i),
    .link(link)
  );

  // Load the next byte to send; the pointer moves past it at once
  function automatic irs_pkg::irs_core_t load_tx(input irs_pkg::irs_core_t c, input logic [7:0] d);
    irs_pkg::irs_core_t r;
    r = c;
    r.shreg = d;
    r.ptr = c.ptr + 8'h01;
    r.rd_pulse = 1'b1;
    r.oe = ~d[7];
    r.cnt = irs_pkg::IRS_CNT_RESET;
    r.st = irs_pkg::IRS_DATA_RD;
    return r;
  endfunction

  // Close a received byte and pull SDA low for the acknowledge
  function automatic irs_pkg::irs_core_t ack_byte(input irs_pkg::irs_core_t c);
    irs_pkg::irs_core_t r;
    r = c;
    r.oe = 1'b1;
    r.from = c.st;
    r.cnt = irs_pkg::IRS_CNT_RESET;
    r.st = irs_pkg::IRS_DEV_ACK;
    return r;
  endfunction

  // Control conditions come from the synchronised pins; both lines share latency
  assign start_ev = q_r.scl_s2 & q_r.scl_s3 & q_r.sda_s3 & ~q_r.sda_s2;
  assign stop_ev = q_r.scl_s2 & q_r.scl_s3 & ~q_r.sda_s3 & q_r.sda_s2;
  // Bit arrival crosses as a toggle; the sampled bit stays put until the next SCL rise
  assign rise_ev = q_r.tg_s2 ^ q_r.tg_s3;
  assign fall_ev = q_r.scl_s3 & ~q_r.scl_s2;

  always_comb
  begin
    q_nxt = q_r;
    q_nxt.req.wr = 1'b0;
    q_nxt.rd_pulse = 1'b0;
    q_nxt.scl_s1 = scl;
    q_nxt.scl_s2 = q_r.scl_s1;
    q_nxt.scl_s3 = q_r.scl_s2;
    q_nxt.sda_s1 = sda_i;
    q_nxt.sda_s2 = q_r.sda_s1;
    q_nxt.sda_s3 = q_r.sda_s2;
    q_nxt.tg_s1 = link.tgl;
    q_nxt.tg_s2 = q_r.tg_s1;
    q_nxt.tg_s3 = q_r.tg_s2;
    if (start_ev)
    begin
      // Repeated START for a read resets too; the pointer survives
      q_nxt.st = irs_pkg::IRS_ADDR;
      q_nxt.cnt = irs_pkg::IRS_CNT_RESET;
      q_nxt.oe = 1'b0;
      q_nxt.busy = 1'b1;
    end
    else if (stop_ev)
    begin
      // A STOP right after the register byte leaves only the pointer changed
      q_nxt.st = irs_pkg::IRS_IDLE;
      q_nxt.cnt = irs_pkg::IRS_CNT_RESET;
      q_nxt.oe = 1'b0;
      q_nxt.busy = 1'b0;
    end
    else
    begin
      unique case (q_r.st)
        irs_pkg::IRS_IDLE, irs_pkg::IRS_IGNORE:
        begin
          q_nxt.oe = 1'b0;
        end
        irs_pkg::IRS_ADDR, irs_pkg::IRS_REG, irs_pkg::IRS_DATA_WR:
        begin
          if (rise_ev)
          begin
            q_nxt.shreg = {q_r.shreg[6:0], link.bit_val};
            q_nxt.cnt = q_r.cnt + 4'h1;
          end
          else if (fall_ev && q_r.cnt == irs_pkg::IRS_BITS_PER_BYTE)
          begin
            if (q_r.st == irs_pkg::IRS_ADDR)
            begin
              if (q_r.shreg[7:1] == irs_pkg::IRS_DEV_ADDR)
              begin
                q_nxt = ack_byte(q_nxt);
                q_nxt.rw = q_r.shreg[0];
              end
              else
              begin
                q_nxt.st = irs_pkg::IRS_IGNORE;
              end
            end
            else if (q_r.st == irs_pkg::IRS_REG)
            begin
              q_nxt.ptr = q_r.shreg;
              q_nxt = ack_byte(q_nxt);
            end
            else
            begin
              q_nxt.req.wr = 1'b1;
              q_nxt.req.addr = q_r.ptr;
              q_nxt.req.wdata = q_r.shreg;
              q_nxt.ptr = q_r.ptr + 8'h01;
              q_nxt = ack_byte(q_nxt);
            end
          end
        end
        irs_pkg::IRS_DEV_ACK:
        begin
          // Low is held from the eighth fall through the whole ninth pulse
          if (rise_ev)
          begin
            q_nxt.cnt = irs_pkg::IRS_ACK_BITS;
          end
          else if (fall_ev && q_r.cnt == irs_pkg::IRS_ACK_BITS)
          begin
            q_nxt.oe = 1'b0;
            q_nxt.cnt = irs_pkg::IRS_CNT_RESET;
            if (q_r.from == irs_pkg::IRS_ADDR && q_r.rw)
            begin
              q_nxt = load_tx(q_nxt, reg_rdata);
            end
            else if (q_r.from == irs_pkg::IRS_ADDR)
            begin
              q_nxt.st = irs_pkg::IRS_REG;
            end
            else
            begin
              q_nxt.st = irs_pkg::IRS_DATA_WR;
            end
          end
        end
        irs_pkg::IRS_DATA_RD:
        begin
          if (rise_ev)
          begin
            q_nxt.cnt = q_r.cnt + 4'h1;
          end
          else if (fall_ev)
          begin
            if (q_r.cnt == irs_pkg::IRS_BITS_PER_BYTE)
            begin
              // Release so the master can drive its acknowledge
              q_nxt.oe = 1'b0;
              q_nxt.cnt = irs_pkg::IRS_CNT_RESET;
              q_nxt.st = irs_pkg::IRS_HOST_ACK;
            end
            else
            begin
              // SDA only changes while SCL is low
              q_nxt.shreg = {q_r.shreg[6:0], 1'b0};
              q_nxt.oe = ~q_r.shreg[6];
            end
          end
        end
        irs_pkg::IRS_HOST_ACK:
        begin
          if (rise_ev)
          begin
            if (link.bit_val)
            begin
              q_nxt.st = irs_pkg::IRS_IGNORE;
            end
            else
            begin
              q_nxt.cnt = irs_pkg::IRS_ACK_BITS;
            end
          end
          else if (fall_ev && q_r.cnt == irs_pkg::IRS_ACK_BITS)
          begin
            q_nxt = load_tx(q_nxt, reg_rdata);
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      q_r <= '0;
      q_r.st <= irs_pkg::IRS_IDLE;
      q_r.from <= irs_pkg::IRS_IDLE;
      q_r.ptr <= irs_pkg::IRS_PTR_RESET;
      q_r.shreg <= irs_pkg::IRS_BYTE_RESET;
      q_r.scl_s1 <= 1'b1;
      q_r.scl_s2 <= 1'b1;
      q_r.scl_s3 <= 1'b1;
      q_r.sda_s1 <= 1'b1;
      q_r.sda_s2 <= 1'b1;
      q_r.sda_s3 <= 1'b1;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // Open drain: the line is only ever pulled low, SCL has no driver at all
  assign sda_o = 1'b0;
  assign sda_oe = q_r.oe;
  assign reg_req = q_r.req;
  assign reg_rd_addr = q_r.ptr;
  assign reg_rd_strobe = q_r.rd_pulse;
  assign bus_busy = q_r.busy;
  assign addressed = (q_r.st != irs_pkg::IRS_IDLE) && (q_r.st != irs_pkg::IRS_IGNORE)
    && (q_r.st != irs_pkg::IRS_ADDR);

endmodule

// file: testbench/irs_slave_checker.sv
`timescale 1ns/1ps
module irs_slave_checker
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire irs_pkg::irs_reg_req_t reg_req,
  input wire logic [7:0] reg_rd_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_strobe,
  input wire logic bus_busy,
  input wire logic addressed
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_start;
    scl && $fell(sda_i);
  endsequence
  sequence s_stop;
    scl && $rose(sda_i);
  endsequence
  property p_od; sda_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  property p_start; s_start |-> ##[1:6] bus_busy; endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_stop; s_stop |-> ##[1:6] !bus_busy; endproperty
  a_stop: assert property (p_stop) else $error("stop missed");
  property p_idle; !bus_busy |-> !sda_oe; endproperty
  a_idle: assert property (p_idle) else $error("sda pulled on idle bus");
  // Three samples high so the scl synchroniser lag cannot fake a change
  property p_hold; scl && $past(scl) && $past(scl, 2) |-> $stable(sda_oe); endproperty
  a_hold: assert property (p_hold) else $error("sda moved while scl high");
  property p_wr_one; reg_req.wr |=> !reg_req.wr; endproperty
  a_wr_one: assert property (p_wr_one) else $error("write strobe too long");
  property p_wr_inc; reg_req.wr |=> reg_rd_addr == $past(reg_req.addr) + 8'h01; endproperty
  a_wr_inc: assert property (p_wr_inc) else $error("pointer not advanced");
  property p_wr_ack; reg_req.wr |-> addressed ##[0:3] sda_oe; endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("data byte not acked");
  property p_rd; reg_rd_strobe |-> addressed ##1 !reg_rd_strobe; endproperty
  a_rd: assert property (p_rd) else $error("bad read strobe");
endmodule
bind irs_slave irs_slave_checker irs_slave_checker_i (.core_clk(core_clk), .rst(rst), .scl(scl),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .reg_req(reg_req), .reg_rd_addr(reg_rd_addr),
  .reg_rdata(reg_rdata), .reg_rd_strobe(reg_rd_strobe), .bus_busy(bus_busy), .addressed(addressed));

// file: testbench/irs_master_model.sv
`timescale 1ns/1ps
module irs_master_model
(
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  real q = 31.25;
  real lo = 0.0;
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic start;
    sda_oe = 1'b0;
    #(q + lo) scl = 1'b1;
    #q sda_oe = 1'b1;
    #q scl = 1'b0;
    #q;
  endtask
  task automatic tx_bit(input logic b, output logic r);
    sda_oe = !b;
    #(q + lo) scl = 1'b1;
    #q r = sda;
    #q scl = 1'b0;
    #q;
  endtask
  // Byte plus ack slot; a 1 releases the line, so acks come from d[0]
  task automatic xb(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
      tx_bit(d[i], r[i]);
  endtask
  task automatic stop;
    sda_oe = 1'b1;
    #(q + lo) scl = 1'b1;
    #q sda_oe = 1'b0;
    #q;
  endtask
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic core_clk;
  logic rst;
  logic scl;
  logic m_oe;
  logic sda_oe;
  logic sda;
  irs_pkg::irs_reg_req_t reg_req;
  logic [7:0] reg_rd_addr;
  logic reg_rd_strobe;
  logic bus_busy;
  logic addressed;
  logic [7:0] bank [256];
  logic [7:0] exp_bank [256];
  logic [8:0] r;
  logic [7:0] p;
  int miscompares = 0;
  int comparisons = 0;
  int wrs = 0;
  int rds = 0;
  int w0;
  int n;
  integer seed = 63361;
  // Pull-up on the open-drain wire
  assign sda = !(m_oe || sda_oe);
  irs_slave irs_slave_i (.core_clk(core_clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
    .reg_req(reg_req), .reg_rd_addr(reg_rd_addr), .reg_rdata(bank[reg_rd_addr]), .reg_rd_strobe(reg_rd_strobe),
    .bus_busy(bus_busy), .addressed(addressed));
  irs_master_model irs_master_model_i (.scl(scl), .sda_oe(m_oe), .sda(sda));
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = !core_clk;
  end
  always @(posedge core_clk)
  begin
    if (reg_req.wr === 1'b1)
    begin
      bank[reg_req.addr] <= reg_req.wdata;
      wrs <= wrs + 1;
    end
    if (reg_rd_strobe === 1'b1)
    begin
      rds <= rds + 1;
    end
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    comparisons++;
    if (seen !== want)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic finish_test;
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Pointer after n auto-increments, wrapping at the top of the bank
  function automatic logic [7:0] exp_ptr(input logic [7:0] a, input int n);
    return 8'(a + n);
  endfunction
  // A released acknowledge slot is expected for any foreign address
  function automatic logic exp_nack(input logic [6:0] a);
    return a != irs_pkg::IRS_DEV_ADDR;
  endfunction
  task automatic sel(input logic [6:0] a, input logic rd);
    irs_master_model_i.start();
    check(bus_busy, 1'b1);
    irs_master_model_i.xb({a, rd, 1'b1}, r);
    check(r[0], exp_nack(a));
    check(addressed, a == irs_pkg::IRS_DEV_ADDR);
  endtask
  task automatic stp;
    irs_master_model_i.stop();
    repeat (20) @(negedge core_clk);
    check(bus_busy, 1'b0);
  endtask
  task automatic wr_regs(input logic [7:0] a, input int cnt);
    logic [7:0] d;
    sel(irs_pkg::IRS_DEV_ADDR, 1'b0);
    irs_master_model_i.xb({a, 1'b1}, r);
    check(r[0], 1'b0);
    for (int i = 0; i < cnt; i++)
    begin
      d = 8'($random(seed));
      exp_bank[8'(a + i)] = d;
      irs_master_model_i.xb({d, 1'b1}, r);
      check(r[0], 1'b0);
    end
  endtask
  task automatic rd_regs(input logic [7:0] a, input int cnt);
    int r0;
    r0 = rds;
    wr_regs(a, 0);
    sel(irs_pkg::IRS_DEV_ADDR, 1'b1);
    for (int i = 0; i < cnt; i++)
    begin
      irs_master_model_i.xb({8'hff, i == cnt - 1}, r);
      check(r[8:1], exp_bank[8'(a + i)]);
    end
    irs_master_model_i.xb(9'h1ff, r);
    check(r, 9'h1ff);
    stp();
    // One load per byte sent; nothing is loaded after the not-acknowledge
    check(9'(rds - r0), 9'(cnt));
    check(reg_rd_addr, exp_ptr(a, cnt));
  endtask
  initial
  begin
    repeat (90000) @(posedge core_clk);
    miscompares++;
    finish_test();
  end
  initial
  begin
    rst = 1'b1;
    for (int i = 0; i < 256; i++)
    begin
      bank[i] = 8'($random(seed));
      exp_bank[i] = bank[i];
    end
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    check({sda_oe, bus_busy, addressed}, 9'h000);
    check(reg_rd_addr, irs_pkg::IRS_PTR_RESET);
    // Every single-bit miss of the own address, direction alternating from bit to bit
    for (int k = 0; k < 7; k++)
    begin
      w0 = wrs;
      sel(irs_pkg::IRS_DEV_ADDR ^ (7'h01 << k), k[0]);
      irs_master_model_i.xb(9'h1fe, r);
      check(r, 9'h1fe);
      stp();
      check(9'(wrs - w0), 9'h000);
    end
    w0 = wrs;
    wr_regs(8'h5a, 0);
    stp();
    check(reg_rd_addr, 8'h5a);
    check(9'(wrs - w0), 9'h000);
    wr_regs(8'hfe, 3);
    stp();
    check(reg_rd_addr, 8'h01);
    rd_regs(8'hfe, 3);
    repeat (6)
    begin
      p = 8'($random(seed));
      n = 1 + ($random(seed) & 3);
      irs_master_model_i.lo = ($random(seed) & 1) ? 100.0 : 0.0;
      wr_regs(p, n);
      stp();
      check(reg_rd_addr, exp_ptr(p, n));
      rd_regs(p, n);
    end
    // START inside a register byte must restart address decoding
    sel(irs_pkg::IRS_DEV_ADDR, 1'b0);
    repeat (4) irs_master_model_i.tx_bit(1'b0, r[0]);
    wr_regs(8'h33, 1);
    stp();
    check(reg_rd_addr, exp_ptr(8'h33, 1));
    rd_regs(8'h33, 1);
    finish_test();
  end
endmodule
